// ### rtl/bdsc_map.svh
// Constants for the bias DAC serial control block
`ifndef BDSC_MAP_SVH
`define BDSC_MAP_SVH
`define BDSC_CODE_RESET     8'hFF
`define BDSC_CODE_SHUTDOWN  8'h00
`define BDSC_CODE_BITS      4'h8
`define BDSC_CLK_HZ         40000000
`define BDSC_OSC_HZ         300000
`define BDSC_OSC_DIV        ((`BDSC_CLK_HZ + `BDSC_OSC_HZ - 1) / `BDSC_OSC_HZ)
`define BDSC_ONTIME_PCT     50
`define BDSC_ONTIME_MAX_PCT 90
`endif

// ### rtl/bdsc_pkg.sv
// Types shared by the bias DAC serial control block
package bdsc_pkg;
    // Serial port pins after synchronising
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } bdsc_serial_s;
    // Converter run state
    typedef enum logic [1:0] {
        BDSC_OFF,
        BDSC_ON_PHASE,
        BDSC_OFF_PHASE
    } bdsc_pwm_e;
endpackage : bdsc_pkg

// ### rtl/bdsc_top.sv
// Serial DAC code port, current-limit flag and PWM gate drive
// Operation
// - Limit flag low while current limit engaged
// - Limit flag changes only on oscillator edge
// - One 8-bit byte loads the DAC code
// - Code resets to all ones
// - All ones gives lowest converter output
// - Write-only port: chip select, clock, data
// - Serial port works even during shutdown
// - Code zero stops converter switching and grounds compensation node
// - Shutdown or undervoltage grounds compensation node
// - DAC voltage is (code plus one) steps
// - Fixed frequency gate drive with on-time
`timescale 1ns/1ps
`include "bdsc_map.svh"
module bdsc_top (
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       arst_n_in,
    // Serial pins from the host
    input  wire logic       cs_n_in,
    input  wire logic       sclk_in,
    input  wire logic       din_in,
    // Analog comparator and supply status
    input  wire logic       limit_engaged_in,
    input  wire logic       undervoltage_in,
    // Converter outputs
    output logic            limit_active_n_out,
    output logic [7:0]      output_setting_code_out,
    output logic [8:0]      setpoint_voltage_out,
    output logic            gate_drive_out,
    output logic            comp_discharge_out,
    output logic            converter_shutdown_out
);
    // Three-stage synchronisers for the pins
    logic [2:0]             cs_n_sync;
    logic [2:0]             sclk_sync;
    logic [2:0]             din_sync;
    logic [2:0]             limit_sync;
    logic [2:0]             uv_sync;
    bdsc_pkg::bdsc_serial_s pins;               // Settled pin levels
    bdsc_pkg::bdsc_serial_s pins_q;             // Previous settled levels
    logic                   lim_lvl;            // Settled limit level
    logic                   uv_lvl;             // Settled undervoltage level
    logic [7:0]             shift;              // Incoming byte
    logic [3:0]             bit_cnt;            // Rising edges seen
    logic                   over;               // More than eight edges seen
    logic [7:0]             code;               // DAC code register
    logic [7:0]             osc_cnt;            // Oscillator divider
    logic                   osc_tick;           // Oscillator edge pulse
    logic [7:0]             on_len;             // Gate on-time in clocks
    bdsc_pkg::bdsc_pwm_e    pwm_st;             // Converter state
    logic                   shdn;               // Converter held off
    logic                   sclk_rise;
    logic                   cs_rise;

    // Pin synchronisers, shift toward bit 2
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cs_n_sync  <= 3'h7;
            sclk_sync  <= 3'h0;
            din_sync   <= 3'h0;
            limit_sync <= 3'h0;
            uv_sync    <= 3'h0;
        end else begin
            cs_n_sync  <= {cs_n_sync[1:0], cs_n_in};
            sclk_sync  <= {sclk_sync[1:0], sclk_in};
            din_sync   <= {din_sync[1:0], din_in};
            limit_sync <= {limit_sync[1:0], limit_engaged_in};
            uv_sync    <= {uv_sync[1:0], undervoltage_in};
        end
    end

    // Accept a level once stages two and three agree
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pins    <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
            pins_q  <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
            lim_lvl <= 1'b0;
            uv_lvl  <= 1'b0;
        end else begin
            if (cs_n_sync[2] == cs_n_sync[1]) pins.cs_n <= cs_n_sync[2];
            if (sclk_sync[2] == sclk_sync[1]) pins.sclk <= sclk_sync[2];
            if (din_sync[2] == din_sync[1]) pins.din <= din_sync[2];
            if (limit_sync[2] == limit_sync[1]) lim_lvl <= limit_sync[2];
            if (uv_sync[2] == uv_sync[1]) uv_lvl <= uv_sync[2];
            pins_q <= pins;
        end
    end

    // Edge detection on settled levels
    assign sclk_rise = pins.sclk & ~pins_q.sclk & ~pins.cs_n;
    assign cs_rise   = pins.cs_n & ~pins_q.cs_n;

    // Shift register, never gated by shutdown
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift   <= 8'h00;
            bit_cnt <= 4'h0;
            over    <= 1'b0;
        end else if (pins.cs_n) begin
            // Idle: ready for a new frame
            bit_cnt <= 4'h0;
            over    <= 1'b0;
        end else if (sclk_rise) begin
            shift <= {shift[6:0], pins.din};
            if (bit_cnt == `BDSC_CODE_BITS) begin
                over <= 1'b1;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    // Code register, committed on deselect after exactly eight edges
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            code <= `BDSC_CODE_RESET;
        end else if (cs_rise && bit_cnt == `BDSC_CODE_BITS && !over) begin
            code <= shift;
        end
    end

    // Internal oscillator divider
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            osc_cnt  <= 8'h00;
            osc_tick <= 1'b0;
        end else if (osc_cnt == 8'(`BDSC_OSC_DIV - 1)) begin
            osc_cnt  <= 8'h00;
            osc_tick <= 1'b1;
        end else begin
            osc_cnt  <= osc_cnt + 8'h01;
            osc_tick <= 1'b0;
        end
    end

    // Limit flag follows the comparator only on oscillator edges
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            limit_active_n_out <= 1'b1;
        end else if (osc_tick) begin
            limit_active_n_out <= ~lim_lvl;
        end
    end

    // Decode of the code that parks the converter
    function automatic logic is_shutdown_code(input logic [7:0] c);
        return (c == `BDSC_CODE_SHUTDOWN);
    endfunction : is_shutdown_code

    // Shutdown and compensation discharge
    assign shdn = is_shutdown_code(code) | uv_lvl;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            converter_shutdown_out <= 1'b0;
            comp_discharge_out     <= 1'b1;
        end else begin
            converter_shutdown_out <= is_shutdown_code(code);
            comp_discharge_out     <= shdn;
        end
    end

    // Setpoint in 1/256 reference steps: code plus one
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            setpoint_voltage_out <= 9'h100;
        end else begin
            setpoint_voltage_out <= {1'b0, code} + 9'h001;
        end
    end
    // Fixed on-time per oscillator period
    assign on_len = 8'((`BDSC_OSC_DIV * `BDSC_ONTIME_PCT) / 100);

    // PWM state: gate on at each oscillator edge, off after on-time
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pwm_st         <= bdsc_pkg::BDSC_OFF;
            gate_drive_out <= 1'b0;
        end else begin
            case (pwm_st)
                bdsc_pkg::BDSC_OFF: begin
                    gate_drive_out <= 1'b0;
                    if (!shdn && osc_tick) begin
                        pwm_st         <= bdsc_pkg::BDSC_ON_PHASE;
                        gate_drive_out <= 1'b1;
                    end
                end
                bdsc_pkg::BDSC_ON_PHASE: begin
                    if (shdn) begin
                        pwm_st         <= bdsc_pkg::BDSC_OFF;
                        gate_drive_out <= 1'b0;
                    end else if (osc_cnt == on_len) begin
                        pwm_st         <= bdsc_pkg::BDSC_OFF_PHASE;
                        gate_drive_out <= 1'b0;
                    end
                end
                bdsc_pkg::BDSC_OFF_PHASE: begin
                    gate_drive_out <= 1'b0;
                    if (shdn) begin
                        pwm_st <= bdsc_pkg::BDSC_OFF;
                    end else if (osc_tick) begin
                        pwm_st         <= bdsc_pkg::BDSC_ON_PHASE;
                        gate_drive_out <= 1'b1;
                    end
                end
                default: begin
                    pwm_st         <= bdsc_pkg::BDSC_OFF;
                    gate_drive_out <= 1'b0;
                end
            endcase
        end
    end

    // Code mirror straight from a flip-flop
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            output_setting_code_out <= `BDSC_CODE_RESET;
        end else begin
            output_setting_code_out <= code;
        end
    end
endmodule : bdsc_top

// ### tb/bdsc_top_chk.sv
// Assertion checker for the bias DAC serial control block
`timescale 1ns/1ps
module bdsc_top_chk (
    // Clock, reset and pins
    input wire logic       sys_clk_in,
    input wire logic       arst_n_in,
    input wire logic       cs_n_in,
    input wire logic       sclk_in,
    input wire logic       din_in,
    input wire logic       limit_engaged_in,
    input wire logic       undervoltage_in,
    // Converter outputs
    input wire logic       limit_active_n_out,
    input wire logic [7:0] output_setting_code_out,
    input wire logic [8:0] setpoint_voltage_out,
    input wire logic       gate_drive_out,
    input wire logic       comp_discharge_out,
    input wire logic       converter_shutdown_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    reset_code_a: assert property (!$past(arst_n_in) |-> output_setting_code_out == 8'hFF)
        else $error("code not all ones after reset");
    dac_step_a: assert property (
        setpoint_voltage_out == {1'b0, output_setting_code_out} + 9'h001)
        else $error("setpoint not code plus one");
    frame_hold_a: assert property (!cs_n_in [*8] |-> $stable(output_setting_code_out))
        else $error("code changed inside a frame");
    shut_code_a: assert property (output_setting_code_out == 8'h00 |-> ##[0:2] converter_shutdown_out)
        else $error("zero code did not shut down");
    shut_gate_a: assert property (converter_shutdown_out [*2] |-> !gate_drive_out)
        else $error("gate switching while shut down");
    shut_comp_a: assert property (converter_shutdown_out |-> ##[0:1] comp_discharge_out)
        else $error("compensation not grounded in shutdown");
    uv_comp_a: assert property ($rose(undervoltage_in) |-> ##[1:6] comp_discharge_out)
        else $error("compensation not grounded in undervoltage");
    limit_low_a: assert property ($rose(limit_engaged_in) |-> ##[1:140] !limit_active_n_out)
        else $error("limit flag did not go low");
    limit_tick_a: assert property ($changed(limit_active_n_out) && !comp_discharge_out
        |-> $rose(gate_drive_out))
        else $error("limit flag moved off an oscillator tick");
    gate_on_a: assert property ($rose(gate_drive_out) |-> (gate_drive_out || comp_discharge_out) [*8])
        else $error("gate pulse too short");
endmodule : bdsc_top_chk
bind bdsc_top bdsc_top_chk u_chk (.*);

// ### tb/bdsc_host_model.sv
// Host model that writes codes over the three-wire serial port
`timescale 1ns/1ps
module bdsc_host_model (
    // Serial pins toward the device
    output logic cs_n_out,
    output logic sclk_out,
    output logic din_out
);
    // Idle: deselected, clock parked low
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out  = 1'b0;
    end
    // One frame of n bits, MSB first, 200 ns clock period
    task automatic send(input logic [15:0] v, input int n);
        #7 cs_n_out = 1'b0;
        #230;
        for (int i = n - 1; i >= 0; i--) begin
            din_out = v[i];
            #100 sclk_out = 1'b1;
            #100 sclk_out = 1'b0;
        end
        #200 cs_n_out = 1'b1;
        din_out = ~din_out;
        #400;
    endtask : send
endmodule : bdsc_host_model

// ### tb/bias_dac_serial_control_tb.sv
// Self-checking bench for the bias DAC serial control block
`timescale 1ns/1ps
module bias_dac_serial_control_tb;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       cs_n, sclk, din, lim_n, gate, comp, shut, seen;
    logic       lim_eng = 1'b0;
    logic       uv = 1'b0;
    logic [7:0] code;
    logic [8:0] setp;
    int         num_errors = 0;
    int         comparisons = 0;
    // 40 MHz clock
    initial forever #12.5 clk = ~clk;
    bdsc_host_model u_host (.cs_n_out(cs_n), .sclk_out(sclk), .din_out(din));
    bdsc_top DUT (.sys_clk_in(clk), .arst_n_in(rst_n), .cs_n_in(cs_n), .sclk_in(sclk),
        .din_in(din), .limit_engaged_in(lim_eng), .undervoltage_in(uv),
        .limit_active_n_out(lim_n), .output_setting_code_out(code),
        .setpoint_voltage_out(setp), .gate_drive_out(gate), .comp_discharge_out(comp),
        .converter_shutdown_out(shut));
    // Compare and count
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic stop_test();
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic wclk(input int n);
        repeat (n) @(negedge clk);
    endtask : wclk
    // Watchdog
    initial begin
        #500us;
        num_errors++;
        stop_test();
    end
    // Test sequence
    initial begin
        wclk(2);
        rst_n = 1'b1;
        wclk(2);
        chk(9'(code), 9'h0FF);
        chk(setp, 9'h100);
        chk(9'({lim_n, comp, shut}), 9'h004);
        u_host.send(16'h005A, 8);
        wclk(12);
        chk(9'(code), 9'h05A);
        chk(setp, 9'h05B);
        u_host.send(16'h0033, 7);
        u_host.send(16'h0133, 9);
        wclk(12);
        chk(9'(code), 9'h05A);
        u_host.send(16'h0000, 8);
        wclk(150);
        chk(9'({gate, shut, comp}), 9'h003);
        u_host.send(16'h003C, 8);
        wclk(12);
        chk(9'({code, shut}), 9'h078);
        seen = 1'b0;
        repeat (140) begin
            wclk(1);
            seen = seen | gate;
        end
        chk(9'(seen), 9'h001);
        lim_eng = 1'b1;
        wclk(150);
        chk(9'(lim_n), 9'h000);
        lim_eng = 1'b0;
        wclk(150);
        chk(9'(lim_n), 9'h001);
        uv = 1'b1;
        wclk(8);
        chk(9'(comp), 9'h001);
        uv = 1'b0;
        wclk(8);
        chk(9'(comp), 9'h000);
        stop_test();
    end
endmodule : bias_dac_serial_control_tb
